// >>> verilog/tcc_map.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
//------------------------------------------
// Register byte offsets
//------------------------------------------
`define TCC_OFF_CTRL 12'h000
`define TCC_OFF_COUNT 12'h004
`define TCC_OFF_RELOAD 12'h008
`define TCC_OFF_CCMODE 12'h00c
`define TCC_OFF_CC0 12'h010
`define TCC_OFF_STATUS 12'h020
`define TCC_OFF_CLEAR 12'h024
`define TCC_OFF_INTEN 12'h028
`define TCC_OFF_CMPOUT 12'h02c
`define TCC_CC_STRIDE 12'h004
//------------------------------------------
// Field positions
//------------------------------------------
`define TCC_CTRL_RUN_LSB 0
`define TCC_CTRL_PRESC_BIT 2
`define TCC_CTRL_RLD_BIT 3
`define TCC_CTRL_W 4
`define TCC_ST_OVF 0
`define TCC_ST_RLD 1
`define TCC_ST_MATCH_LSB 2
//------------------------------------------
// Reset values and counts
//------------------------------------------
`define TCC_CTRL_RST 4'h0
`define TCC_PRESC_W 5
`define TCC_PRESC_FAST 5'h0c
`define TCC_PRESC_SLOW 5'h18
`endif

// >>> verilog/tcc_pkg.sv
// Types shared by the timer and its compare/capture channels.
package tcc_pkg;
    // Counting source of the timer.
    typedef enum logic [1:0] {
        TCC_RUN_STOP = 2'h0,
        TCC_RUN_TIMER = 2'h1,
        TCC_RUN_EVENT = 2'h2,
        TCC_RUN_GATED = 2'h3
    } tcc_run_e;
    // Function of one compare/capture channel.
    typedef enum logic [1:0] {
        TCC_CC_OFF = 2'h0,
        TCC_CC_COMPARE = 2'h1,
        TCC_CC_CAP_EXT = 2'h2,
        TCC_CC_CAP_SW = 2'h3
    } tcc_ccmode_e;
endpackage : tcc_pkg

// >>> verilog/tcc_channel.sv
// One compare/capture channel of the timer.
`timescale 1ns/1ns
`default_nettype none
module tcc_channel
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire tcc_ccmode_e mode,
    input wire logic wr_en,
    input wire logic [CNT_W-1:0] wr_data,
    input wire logic [CNT_W-1:0] count,
    input wire logic cap_in,
    output logic [CNT_W-1:0] cc_value,
    output logic cmp_out,
    output logic match,
    output logic cap
);
    logic [CNT_W-1:0] cc_q, cc_d;
    logic cap_prev_q, cmp_q, cmp_d, eq_q, eq_d, match_q, match_d, cap_q, cap_d;
    logic cap_fall;

    // Capture, compare and edge detection next values.
    always_comb begin
        cap_fall = cap_prev_q & ~cap_in; // RULE12
        cap_d = ((mode == TCC_CC_CAP_EXT) && cap_fall) || // RULE9
                ((mode == TCC_CC_CAP_SW) && wr_en); // RULE10
        cc_d = cc_q;
        if (cap_d) begin
            cc_d = count; // RULE9 RULE10
        end else if (wr_en) begin
            cc_d = wr_data;
        end
        eq_d = (mode == TCC_CC_COMPARE) && (count == cc_q); // RULE7
        match_d = eq_d & ~eq_q; // RULE8
        cmp_d = (mode == TCC_CC_COMPARE) && (count >= cc_q); // RULE8
    end

    // State registers of the channel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_q <= '0;
            cap_prev_q <= 1'b0;
            cmp_q <= 1'b0;
            eq_q <= 1'b0;
            match_q <= 1'b0;
            cap_q <= 1'b0;
        end else begin
            cc_q <= cc_d;
            cap_prev_q <= cap_in;
            cmp_q <= cmp_d;
            eq_q <= eq_d;
            match_q <= match_d;
            cap_q <= cap_d;
        end
    end

    assign cc_value = cc_q;
    assign cmp_out = cmp_q;
    assign match = match_q;
    assign cap = cap_q;

    // A falling capture input in external mode latches the count.
    property p_cap_ext;
        @(posedge pclk) disable iff (!presetn)
        (mode == TCC_CC_CAP_EXT) && cap_prev_q && !cap_in |=> cc_q == $past(count) && cap_q;
    endproperty
    a_cap_ext: assert property (p_cap_ext) else $error("external capture missed"); // RULE9
    // A software write in software capture mode latches the count, not the data.
    property p_cap_sw;
        @(posedge pclk) disable iff (!presetn)
        (mode == TCC_CC_CAP_SW) && wr_en |=> cc_q == $past(count);
    endproperty
    a_cap_sw: assert property (p_cap_sw) else $error("software capture missed"); // RULE10
    // Reaching the compare value raises the match and the output together.
    property p_cmp;
        @(posedge pclk) disable iff (!presetn)
        (mode == TCC_CC_COMPARE) && (count == cc_q) && !eq_q |=> match_q && cmp_q;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare match not signalled"); // RULE7
endmodule : tcc_channel
`default_nettype wire

// >>> verilog/tcc_timer.sv
// Timer/counter with compare/capture channels behind an APB slave.
//------------------------------------------
// Notes on behaviour
// RULE1 - In timer mode the count steps once every 12 or every 24 clocks.
// RULE2 - In event mode the count steps on a 1-to-0 change of the count input, sampled each cycle.
// RULE3 - The step for a detected falling count input lands one cycle after detection.
// RULE4 - In gated mode the count steps only while the gate input is high and holds otherwise.
// RULE5 - In reload mode 0 every overflow loads the reload value into the count.
// RULE6 - In reload mode 1 a falling reload trigger input loads the reload value.
// RULE7 - The count is compared continuously with each of the four channel registers.
// RULE8 - Each compare drives its compare output line and raises its match interrupt.
// RULE9 - Capture mode 0 latches the count into the channel on its falling capture input.
// RULE10 - Capture mode 1 latches the count into the channel on a software write to it.
// RULE11 - A wrap from all ones to zero sets a sticky overflow flag that can interrupt.
// RULE12 - Outside inputs hold each level for at least one cycle so every edge is seen.
//------------------------------------------
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.svh"

module tcc_timer
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int NUM_CC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_event_input,
    input wire logic gate_input,
    input wire logic reload_trigger_input,
    input wire logic [NUM_CC-1:0] capture_event_input,
    output logic [NUM_CC-1:0] compare_out,
    output logic irq
);
    localparam int ST_W = 2 + 2 * NUM_CC;
    localparam int CAP_LSB = `TCC_ST_MATCH_LSB + NUM_CC;

    //------------------------------------------
    // Elaboration checks
    //------------------------------------------
    if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
        $error("counter width must lie between 8 and 32");
    end
    if (NUM_CC < 1 || NUM_CC > 4) begin : g_bad_cc
        $error("between one and four channels fit the register map");
    end

    //------------------------------------------
    // Declarations
    //------------------------------------------
    logic [`TCC_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [CNT_W-1:0] count_q, count_d, reload_q, reload_d;
    logic [2*NUM_CC-1:0] ccmode_q, ccmode_d;
    logic [ST_W-1:0] status_q, status_d, inten_q, inten_d, st_set, st_clr;
    logic [`TCC_PRESC_W-1:0] presc_q, presc_d, presc_last;
    logic cnt_prev_q, cnt_fall_q, cnt_fall_d, rld_prev_q, rld_fall;
    logic tick, advance, ovf, rld_req, irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic acc, bus_wr, setup, ctrl_wr, count_wr;
    logic [NUM_CC-1:0] cc_wr, cc_match, cc_cap, cmp_q;
    logic [CNT_W-1:0] cc_val [NUM_CC];
    tcc_run_e run;
    logic presc_slow, rld_mode;

    //------------------------------------------
    // Bus decode
    //------------------------------------------
    // APB answers in the access cycle; writes land at that edge.
    assign acc = psel & penable;
    assign setup = psel & ~penable;
    assign bus_wr = acc & pwrite;
    assign ctrl_wr = bus_wr && (paddr == `TCC_OFF_CTRL);
    assign count_wr = bus_wr && (paddr == `TCC_OFF_COUNT);
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Control fields.
    assign run = tcc_run_e'(ctrl_q[`TCC_CTRL_RUN_LSB +: 2]);
    assign presc_slow = ctrl_q[`TCC_CTRL_PRESC_BIT];
    assign rld_mode = ctrl_q[`TCC_CTRL_RLD_BIT];

    //------------------------------------------
    // Prescaler
    //------------------------------------------
    // Divides the clock into a tick every 12 or 24 cycles.
    always_comb begin
        presc_last = presc_slow ? (`TCC_PRESC_SLOW - 5'h01) : (`TCC_PRESC_FAST - 5'h01);
        tick = 1'b0;
        presc_d = presc_q;
        if (ctrl_wr || run == TCC_RUN_STOP || run == TCC_RUN_EVENT) begin
            presc_d = '0;
        end else if (presc_q == presc_last) begin
            tick = 1'b1; // RULE1
            presc_d = '0;
        end else begin
            presc_d = presc_q + 5'h01;
        end
    end

    // Prescaler register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_d;
        end
    end

    //------------------------------------------
    // Input edge detection
    //------------------------------------------
    // Inputs are sampled once per cycle; a level shorter than a cycle can be missed.
    always_comb begin
        cnt_fall_d = cnt_prev_q & ~count_event_input; // RULE2 RULE12
        rld_fall = rld_prev_q & ~reload_trigger_input; // RULE12
    end

    // Sampled input levels and the delayed count edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_prev_q <= 1'b0;
            cnt_fall_q <= 1'b0;
            rld_prev_q <= 1'b0;
        end else begin
            cnt_prev_q <= count_event_input;
            cnt_fall_q <= cnt_fall_d; // RULE3
            rld_prev_q <= reload_trigger_input;
        end
    end

    //------------------------------------------
    // Counter
    //------------------------------------------
    // Selects the step source, then applies write, reload or step.
    always_comb begin
        case (run)
            TCC_RUN_TIMER: advance = tick; // RULE1
            TCC_RUN_EVENT: advance = cnt_fall_q; // RULE2 RULE3
            TCC_RUN_GATED: advance = tick & gate_input; // RULE4
            default: advance = 1'b0;
        endcase
        ovf = advance && (count_q == {CNT_W{1'b1}}); // RULE11
        rld_req = (!rld_mode && ovf) || (rld_mode && rld_fall); // RULE5 RULE6
        count_d = count_q;
        if (count_wr) begin
            count_d = pwdata[CNT_W-1:0];
        end else if (rld_req) begin
            count_d = reload_q; // RULE5 RULE6
        end else if (advance) begin
            count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Counter register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    //------------------------------------------
    // Compare/capture channels
    //------------------------------------------
    // One channel per compare/capture register.
    for (genvar g = 0; g < NUM_CC; g++) begin : g_cc
        localparam logic [11:0] CC_ADDR = `TCC_OFF_CC0 + 12'(g) * `TCC_CC_STRIDE;
        assign cc_wr[g] = bus_wr && (paddr == CC_ADDR);
        tcc_channel #(
            .CNT_W(CNT_W)
        ) u_cc (
            .pclk(pclk),
            .presetn(presetn),
            .mode(tcc_ccmode_e'(ccmode_q[2*g +: 2])),
            .wr_en(cc_wr[g]),
            .wr_data(pwdata[CNT_W-1:0]),
            .count(count_q),
            .cap_in(capture_event_input[g]),
            .cc_value(cc_val[g]),
            .cmp_out(cmp_q[g]),
            .match(cc_match[g]),
            .cap(cc_cap[g])
        );
    end
    assign compare_out = cmp_q; // RULE8

    //------------------------------------------
    // Configuration, status and interrupt
    //------------------------------------------
    // Software writes; hardware events set sticky bits and win over a clear.
    always_comb begin
        ctrl_d = ctrl_wr ? pwdata[`TCC_CTRL_W-1:0] : ctrl_q;
        reload_d = (bus_wr && paddr == `TCC_OFF_RELOAD) ? pwdata[CNT_W-1:0] : reload_q;
        ccmode_d = (bus_wr && paddr == `TCC_OFF_CCMODE) ? pwdata[2*NUM_CC-1:0] : ccmode_q;
        inten_d = (bus_wr && paddr == `TCC_OFF_INTEN) ? pwdata[ST_W-1:0] : inten_q;
        st_clr = (bus_wr && paddr == `TCC_OFF_CLEAR) ? pwdata[ST_W-1:0] : '0;
        st_set = '0;
        st_set[`TCC_ST_OVF] = ovf; // RULE11
        st_set[`TCC_ST_RLD] = rld_mode && rld_fall;
        st_set[`TCC_ST_MATCH_LSB +: NUM_CC] = cc_match; // RULE8
        st_set[CAP_LSB +: NUM_CC] = cc_cap;
        status_d = (status_q & ~st_clr) | st_set;
        irq_d = |(status_d & inten_d);
    end

    // Configuration and status registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TCC_CTRL_RST;
            reload_q <= '0;
            ccmode_q <= '0;
            inten_q <= '0;
            status_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            reload_q <= reload_d;
            ccmode_q <= ccmode_d;
            inten_q <= inten_d;
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end
    assign irq = irq_q;

    //------------------------------------------
    // Read data
    //------------------------------------------
    // Read data and error are prepared in the setup cycle.
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            pslverr_d = 1'b0;
            case (paddr)
                `TCC_OFF_CTRL: prdata_d[`TCC_CTRL_W-1:0] = ctrl_q;
                `TCC_OFF_COUNT: prdata_d[CNT_W-1:0] = count_q;
                `TCC_OFF_RELOAD: prdata_d[CNT_W-1:0] = reload_q;
                `TCC_OFF_CCMODE: prdata_d[2*NUM_CC-1:0] = ccmode_q;
                `TCC_OFF_STATUS: prdata_d[ST_W-1:0] = status_q;
                `TCC_OFF_CLEAR: prdata_d = 32'h0000_0000;
                `TCC_OFF_INTEN: prdata_d[ST_W-1:0] = inten_q;
                `TCC_OFF_CMPOUT: prdata_d[NUM_CC-1:0] = cmp_q;
                default: pslverr_d = 1'b1;
            endcase
            for (int i = 0; i < NUM_CC; i++) begin
                if (paddr == `TCC_OFF_CC0 + 12'(i) * `TCC_CC_STRIDE) begin
                    prdata_d[CNT_W-1:0] = cc_val[i];
                    pslverr_d = 1'b0;
                end
            end
        end
    end

    // Read data registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    //------------------------------------------
    // Checks
    //------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Helper: cycles since the last tick while the setting is unchanged.
    logic [`TCC_PRESC_W-1:0] gap_q;
    logic gap_ok_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end else if (ctrl_wr || !(run == TCC_RUN_TIMER || run == TCC_RUN_GATED)) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end else if (tick) begin
            gap_q <= '0;
            gap_ok_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 5'h01;
        end
    end

    property p_presc_period;
        tick && gap_ok_q |-> gap_q == (presc_slow ? 5'h17 : 5'h0b);
    endproperty
    a_presc_period: assert property (p_presc_period) else $error("prescaler period wrong"); // RULE1

    sequence s_evt_detect;
        run == TCC_RUN_EVENT && cnt_prev_q && !count_event_input && !bus_wr && !rld_req;
    endsequence
    sequence s_evt_quiet;
        !bus_wr && !rld_req;
    endsequence
    property p_evt_step;
        s_evt_detect ##1 s_evt_quiet |=> count_q == $past(count_q) + 1'b1;
    endproperty
    a_evt_step: assert property (p_evt_step) else $error("event step missing"); // RULE2
    property p_evt_late;
        s_evt_detect |=> count_q == $past(count_q);
    endproperty
    a_evt_late: assert property (p_evt_late) else $error("event step too early"); // RULE3

    property p_gate_hold;
        run == TCC_RUN_GATED && !gate_input && !bus_wr && !rld_req |=> $stable(count_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated count moved"); // RULE4

    property p_auto_reload;
        !rld_mode && advance && count_q == {CNT_W{1'b1}} && !count_wr
            |=> count_q == $past(reload_q) && status_q[`TCC_ST_OVF];
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("overflow reload missed"); // RULE5

    property p_pin_reload;
        rld_mode && rld_prev_q && !reload_trigger_input && !count_wr
            |=> count_q == $past(reload_q) && status_q[`TCC_ST_RLD];
    endproperty
    a_pin_reload: assert property (p_pin_reload) else $error("pin reload missed"); // RULE6

    property p_ovf_flag;
        ovf |=> status_q[`TCC_ST_OVF] && count_q != {CNT_W{1'b1}};
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // RULE11

    property p_match_irq;
        |cc_match && |(inten_q[`TCC_ST_MATCH_LSB +: NUM_CC] & cc_match) |=> irq;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match interrupt missing"); // RULE8
endmodule : tcc_timer
`default_nettype wire

// >>> testbench/tcc_pins.sv
// Model of the outside pins that feed the timer: count, gate, reload and capture inputs.
`timescale 1ns/1ns
`default_nettype none
module tcc_pins #(
    parameter int NUM_CC = 4
) (
    input wire logic pclk,
    input wire logic drop_req,
    input wire logic [2:0] drop_sel,
    input wire logic gate_req,
    output logic count_event_input,
    output logic gate_input,
    output logic reload_trigger_input,
    output logic [NUM_CC-1:0] capture_event_input
);
    // One bit per edge input (0 count, 1 reload, 2 and up capture); a set bit pulls it low.
    logic [NUM_CC+1:0] low_q = '0;
    logic gate_q = 1'b0;

    // Pins follow the requests one edge later and hold each level as long as asked.
    always @(posedge pclk) begin
        low_q <= drop_req ? ({{(NUM_CC+1){1'b0}}, 1'b1} << drop_sel) : '0;
        gate_q <= gate_req;
    end

    // Edge inputs rest high so that only a deliberate drop is seen; the gate rests closed.
    assign count_event_input = ~low_q[0];
    assign reload_trigger_input = ~low_q[1];
    assign capture_event_input = ~low_q[NUM_CC+1:2];
    assign gate_input = gate_q;
endmodule : tcc_pins
`default_nettype wire

// >>> testbench/tcc_timer_test.sv
// Self-checking bench for the timer, its channels and its APB registers.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.svh"
module tcc_timer_test
    import tcc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic pready, pslverr, cnt_in, gate_in, rld_in, irq, e;
    logic [3:0] cap_in, compare_out;
    int error_cnt = 0;
    int samples_checked = 0;
    logic drop_req = 1'b0;
    logic [2:0] drop_sel = 3'h0;
    logic gate_req = 1'b0;

    // Clock of 100 MHz.
    always #5 pclk = ~pclk;

    tcc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_event_input(cnt_in), .gate_input(gate_in),
        .reload_trigger_input(rld_in), .capture_event_input(cap_in),
        .compare_out(compare_out), .irq(irq));
    tcc_pins pins (.pclk(pclk), .drop_req(drop_req), .drop_sel(drop_sel), .gate_req(gate_req),
        .count_event_input(cnt_in), .gate_input(gate_in),
        .reload_trigger_input(rld_in), .capture_event_input(cap_in));

    //------------------------------------------
    // Bus cycles and comparisons
    //------------------------------------------
    // One APB transfer: setup, then access held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, v, e);
    endtask : wr

    // Reads a register; only places past the last register answer with an error.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, v, e);
        chk(what, exp, v);
        chk("slverr", {31'h0, a >= 12'h030}, {31'h0, e});
    endtask : rd

    // Asks the pin model to pull one input low for two cycles, then leaves it high for two.
    task automatic pulse(input int sel);
        @(posedge pclk);
        drop_req <= 1'b1;
        drop_sel <= 3'(sel);
        repeat (2) @(posedge pclk);
        drop_req <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : pulse

    // Opens or closes the gate just after a clock edge.
    task automatic set_gate(input logic open);
        @(posedge pclk);
        gate_req <= open;
    endtask : set_gate

    function automatic logic [3:0] ge_mask(input int c);
        for (int k = 0; k < 4; k++) ge_mask[k] = (c >= k + 2);
    endfunction : ge_mask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    //------------------------------------------
    // Scenarios
    //------------------------------------------
    // Watchdog cuts a hang short long after the sequence should be over.
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("ERROR watchdog expected finish seen timeout");
        report_and_stop();
    end

    // Main sequence of register calls with their expected values.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TCC_OFF_CTRL, 32'h0, "ctrl reset");
        wr(`TCC_OFF_STATUS, 32'hffff);
        rd(`TCC_OFF_STATUS, 32'h0, "status read only");
        rd(12'h040, 32'h0, "unmapped");
        for (int p = 0; p < 2; p++) begin
            wr(`TCC_OFF_COUNT, 32'h0);
            wr(`TCC_OFF_CTRL, {29'h0, p[0], TCC_RUN_TIMER});
            repeat (p ? 129 : 123) @(posedge pclk);
            wr(`TCC_OFF_CTRL, 32'h0);
            rd(`TCC_OFF_COUNT, p ? 32'h5 : 32'ha, "timer steps");
        end
        wr(`TCC_OFF_CTRL, {30'h0, TCC_RUN_GATED});
        repeat (60) @(posedge pclk);
        rd(`TCC_OFF_COUNT, 32'h5, "gate closed");
        set_gate(1'b1);
        repeat (60) @(posedge pclk);
        set_gate(1'b0);
        apb(1'b0, `TCC_OFF_COUNT, 32'h0, v, e);
        chk("gate open", 32'h1, {31'h0, v > 32'h5});
        repeat (40) @(posedge pclk);
        rd(`TCC_OFF_COUNT, v, "gate hold");
        wr(`TCC_OFF_CTRL, {30'h0, TCC_RUN_EVENT});
        wr(`TCC_OFF_COUNT, 32'h0);
        repeat (3) pulse(0);
        rd(`TCC_OFF_COUNT, 32'h3, "event count");
        wr(`TCC_OFF_RELOAD, 32'hfff0);
        wr(`TCC_OFF_COUNT, 32'hfffe);
        repeat (2) pulse(0);
        rd(`TCC_OFF_COUNT, 32'hfff0, "auto reload");
        rd(`TCC_OFF_STATUS, 32'h1, "overflow flag");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`TCC_OFF_INTEN, 32'h1);
        @(negedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`TCC_OFF_CLEAR, 32'h1);
        @(negedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`TCC_OFF_CTRL, {28'h0, 2'h2, TCC_RUN_EVENT});
        wr(`TCC_OFF_COUNT, 32'h1234);
        wr(`TCC_OFF_RELOAD, 32'h0055);
        pulse(1);
        rd(`TCC_OFF_COUNT, 32'h55, "pin reload");
        wr(`TCC_OFF_COUNT, 32'hffff);
        pulse(0);
        rd(`TCC_OFF_COUNT, 32'h0, "wrap");
        rd(`TCC_OFF_STATUS, 32'h3, "reload flags");
        wr(`TCC_OFF_CLEAR, 32'h3ff);
        wr(`TCC_OFF_CCMODE, 32'h55);
        for (int i = 0; i < 4; i++) wr(`TCC_OFF_CC0 + 12'(4 * i), 32'(i + 2));
        wr(`TCC_OFF_CLEAR, 32'h3ff);
        wr(`TCC_OFF_INTEN, 32'h3c);
        repeat (2) @(negedge pclk);
        chk("irq idle", 32'h0, {31'h0, irq});
        for (int c = 0; c < 6; c++) begin
            @(negedge pclk);
            chk("compare lines", {28'h0, ge_mask(c)}, {28'h0, compare_out});
            pulse(0);
        end
        chk("match irq", 32'h1, {31'h0, irq});
        rd(`TCC_OFF_CMPOUT, 32'hf, "compare reg");
        rd(`TCC_OFF_STATUS, 32'h3c, "match flags");
        wr(`TCC_OFF_CTRL, 32'h0);
        wr(`TCC_OFF_CCMODE, 32'haa);
        wr(`TCC_OFF_COUNT, 32'h0321);
        wr(`TCC_OFF_CLEAR, 32'h3ff);
        for (int i = 0; i < 4; i++) begin
            pulse(i + 2);
            rd(`TCC_OFF_CC0 + 12'(4 * i), 32'h321, "capture pin");
        end
        rd(`TCC_OFF_STATUS, 32'h3c0, "capture flags");
        wr(`TCC_OFF_CCMODE, 32'hff);
        wr(`TCC_OFF_COUNT, 32'h0456);
        for (int i = 0; i < 4; i++) begin
            wr(`TCC_OFF_CC0 + 12'(4 * i), 32'h0000beef);
            rd(`TCC_OFF_CC0 + 12'(4 * i), 32'h456, "capture write");
        end
        report_and_stop();
    end
endmodule : tcc_timer_test
`default_nettype wire
